// ==== logic/pefm_mux.sv ====
`timescale 1ns/1ps
`default_nettype none
module pefm_mux (
   input  wire logic                  clk,         // 40 MHz clock
   input  wire logic                  srst,        // Sync reset, high
   input  wire logic [7:0]            address,     // Byte address
   input  wire logic                  read,        // Read request
   input  wire logic                  write,       // Write request
   input  wire logic [3:0]            byteenable,  // Byte lanes
   input  wire logic [31:0]           writedata,   // Write data
   output logic [31:0]                readdata,    // Read data
   output logic                       waitrequest, // Stall
   input  wire pefm_pkg::pefm_periph_s periph,     // Peripheral controls
   output pefm_pkg::pefm_fabric_s     fabric,      // Peripheral inputs
   input  wire logic [7:0]            pe_pad_in,   // Port E pad levels
   output logic [7:0]                 pe_pad_out,  // Port E drive value
   output logic [7:0]                 pe_pad_oe_n, // Port E drive, low on
   output logic [7:0]                 pe_pad_pu,   // Port E pull-ups
   input  wire logic [7:0]            pf_pad_in,   // Port F pad levels
   output logic [7:0]                 pf_pad_out,  // Port F drive value
   output logic [7:0]                 pf_pad_oe_n, // Port F drive, low on
   output logic [7:0]                 pf_pad_pu,   // Port F pull-ups
   output logic [7:0]                 pf_din_off   // F digital path off
);
   import pefm_pkg::*;

   // ----------------------------------------------------------
   // Registers
   // ----------------------------------------------------------
   logic [7:0]  pe_port_r, pe_ddr_r;   // Port E data, direction
   logic [7:0]  pf_port_r, pf_ddr_r;   // Port F data, direction
   logic [2:0]  misc_r;                // Pud, comparator disables
   logic [7:0]  adc_dis_r;             // F digital input disables
   logic        wait_r;                // Waitrequest state
   logic [31:0] rdata_r;               // Read data
   logic        wr_go, rd_go;          // Accepted write, read fetch
   logic        pud;                   // Global pull-up disable

   assign pud   = misc_r[PEFM_MISC_PUD];
   assign wr_go = write & ~wait_r;
   assign rd_go = read & wait_r;

   // ----------------------------------------------------------
   // Avalon slave
   // ----------------------------------------------------------
   // One wait cycle, then accept
   always_ff @(posedge clk) begin
      if (srst) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= ~((read | write) & wait_r);
      end
   end

   // Write decode, lane 0 only
   always_ff @(posedge clk) begin
      if (srst) begin
         pe_port_r <= PEFM_RST8;
         pe_ddr_r  <= PEFM_RST8;
         pf_port_r <= PEFM_RST8;
         pf_ddr_r  <= PEFM_RST8;
         misc_r    <= PEFM_RST8[2:0];
         adc_dis_r <= PEFM_RST8;
      end else if (wr_go && byteenable[0]) begin
         case (address)
            PEFM_PE_OUT:  pe_port_r <= writedata[7:0];
            PEFM_PE_DIR:  pe_ddr_r  <= writedata[7:0];
            PEFM_PF_OUT:  pf_port_r <= writedata[7:0];
            PEFM_PF_DIR:  pf_ddr_r  <= writedata[7:0];
            PEFM_MISC:    misc_r    <= writedata[2:0];
            PEFM_ADC_DIS: adc_dis_r <= writedata[7:0];
            default: ;    // Unmapped: ignored
         endcase
      end
   end

   logic [7:0] pe_pin_q, pf_pin_q;     // Filtered pad levels

   // Read mux, sampled in the wait cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_r <= '0;
      end else if (rd_go) begin
         case (address)
            PEFM_PE_OUT:  rdata_r <= {24'h0, pe_port_r};
            PEFM_PE_DIR:  rdata_r <= {24'h0, pe_ddr_r};
            PEFM_PF_OUT:  rdata_r <= {24'h0, pf_port_r};
            PEFM_PF_DIR:  rdata_r <= {24'h0, pf_ddr_r};
            PEFM_MISC:    rdata_r <= {29'h0, misc_r};
            PEFM_ADC_DIS: rdata_r <= {24'h0, adc_dis_r};
            PEFM_PE_PIN:  rdata_r <= {24'h0, pe_pin_q};
            PEFM_PF_PIN:  rdata_r <= {24'h0, pf_pin_q};
            default:      rdata_r <= '0; // Unmapped reads zero
         endcase
      end
   end

   assign waitrequest = wait_r;
   assign readdata    = rdata_r;

   // ----------------------------------------------------------
   // Pad input filter
   // ----------------------------------------------------------
   logic [7:0] pe_s1, pe_s2, pe_s3;    // Port E sync chain
   logic [7:0] pf_s1, pf_s2, pf_s3;    // Port F sync chain

   // Three stages; accept when stages two and three agree
   always_ff @(posedge clk) begin
      if (srst) begin
         {pe_s1, pe_s2, pe_s3} <= '0;
         {pf_s1, pf_s2, pf_s3} <= '0;
         pe_pin_q <= '0;
         pf_pin_q <= '0;
      end else begin
         {pe_s3, pe_s2, pe_s1} <= {pe_s2, pe_s1, pe_pad_in};
         {pf_s3, pf_s2, pf_s1} <= {pf_s2, pf_s1, pf_pad_in};
         pe_pin_q <= (pe_s2 & ~(pe_s2 ^ pe_s3))
                   | (pe_pin_q & (pe_s2 ^ pe_s3));
         pf_pin_q <= (pf_s2 & ~(pf_s2 ^ pf_s3))
                   | (pf_pin_q & (pf_s2 ^ pf_s3));
      end
   end

   // ----------------------------------------------------------
   // Override tables
   // ----------------------------------------------------------
   pefm_ovr_s e_ov, f_ov;              // Port E, Port F overrides
   logic      txen, rxen, jen;         // Shorthands

   assign txen = periph.usart0_tx_enable | periph.prog_mode;
   assign rxen = periph.usart0_rx_enable | periph.prog_mode;
   assign jen  = periph.jtag_en;

   // Port E overrides
   always_comb begin
      e_ov = '0;
      // Pin 5,4,3 values from compare outputs; direction from register
      e_ov.pv_oe[5:3] = periph.t3_oc_en;
      e_ov.pv_ov[5:3] = periph.t3_oc;
      // Interrupt enables force input path on
      e_ov.die_oe[7:4] = periph.irq_en;
      e_ov.die_ov[7:4] = periph.irq_en;
      // Comparator inputs, digital side disabled
      e_ov.die_oe[3] = misc_r[PEFM_MISC_NEG];
      e_ov.die_oe[2] = misc_r[PEFM_MISC_POS];
      // Clock out value in synchronous mode
      e_ov.pv_oe[2] = periph.usart0_mode_select;
      e_ov.pv_ov[2] = periph.usart0_xck_out;
      // Transmit or programming data on pin 1
      e_ov.pu_oe[1] = txen;
      e_ov.dd_oe[1] = txen;
      e_ov.dd_ov[1] = 1'b1;
      e_ov.pv_oe[1] = txen;
      e_ov.pv_ov[1] = periph.prog_mode ?
                      periph.serial_prog_data_out :
                      periph.usart0_tx_line;
      // Receive or programming input on pin 0
      e_ov.pu_oe[0] = rxen;
      e_ov.pu_ov[0] = pe_port_r[0] & ~pud;
      e_ov.dd_oe[0] = rxen;
   end

   // Port F overrides
   always_comb begin
      f_ov = '0;
      // Test port owns F7..F4
      f_ov.pu_oe  = jen ? PEFM_JTAG_PIN : '0;
      f_ov.pu_ov  = jen ? PEFM_JTAG_PU : '0;
      f_ov.dd_oe  = jen ? PEFM_JTAG_PIN : '0;
      f_ov.pv_oe  = jen ? PEFM_JTAG_PIN : '0;
      f_ov.dd_ov[6] = periph.jtag_shift;
      f_ov.pv_ov[6] = periph.jtag_tdo;
      // Analog channels may disable digital inputs
      f_ov.die_oe = adc_dis_r | (jen ? PEFM_JTAG_PIN : '0);
      f_ov.die_ov = jen ? PEFM_JTAG_PU : '0;
   end

   // ----------------------------------------------------------
   // Pin resolution
   // ----------------------------------------------------------
   logic [7:0] e_dir, e_val, e_pu, e_die; // Port E resolved
   logic [7:0] f_dir, f_val, f_pu, f_die; // Port F resolved

   // Override value wins wherever its enable is set
   always_comb begin
      e_dir = (e_ov.dd_oe & e_ov.dd_ov) | (~e_ov.dd_oe & pe_ddr_r);
      e_val = (e_ov.pv_oe & e_ov.pv_ov) | (~e_ov.pv_oe & pe_port_r);
      e_pu  = (e_ov.pu_oe & e_ov.pu_ov)
            | (~e_ov.pu_oe & pe_port_r & ~pe_ddr_r & {8{~pud}});
      e_die = ~e_ov.die_oe | e_ov.die_ov;
      f_dir = (f_ov.dd_oe & f_ov.dd_ov) | (~f_ov.dd_oe & pf_ddr_r);
      f_val = (f_ov.pv_oe & f_ov.pv_ov) | (~f_ov.pv_oe & pf_port_r);
      f_pu  = (f_ov.pu_oe & f_ov.pu_ov)
            | (~f_ov.pu_oe & pf_port_r & ~pf_ddr_r & {8{~pud}});
      f_die = ~f_ov.die_oe | f_ov.die_ov;
   end

   // Registered pad controls; test pull-ups survive reset
   always_ff @(posedge clk) begin
      if (srst) begin
         pe_pad_out  <= '0;
         pe_pad_oe_n <= '1;
         pe_pad_pu   <= '0;
         pf_pad_out  <= '0;
         pf_pad_oe_n <= '1;
         pf_pad_pu   <= jen ? PEFM_JTAG_PU : '0;
         pf_din_off  <= '0;
      end else begin
         pe_pad_out  <= e_val;
         pe_pad_oe_n <= ~e_dir;
         pe_pad_pu   <= e_pu;
         pf_pad_out  <= f_val;
         pf_pad_oe_n <= ~f_dir;
         pf_pad_pu   <= f_pu;
         pf_din_off  <= ~f_die;
      end
   end

   // ----------------------------------------------------------
   // Peripheral inputs
   // ----------------------------------------------------------
   logic [7:0] e_in, f_in;             // Gated digital inputs

   assign e_in = pe_pin_q & e_die;
   assign f_in = pf_pin_q & f_die;

   // Route gated pad levels to the peripherals
   always_ff @(posedge clk) begin
      if (srst) begin
         fabric <= '0;
      end else begin
         fabric.ext_irq_src       <= e_in[7:4];
         fabric.timer3_capture_in <= e_in[7];
         fabric.timer3_count_src  <= e_in[6];
         fabric.usart0_rx_line    <= e_in[0];
         fabric.usart0_ext_clock  <= e_in[2]
                                   & periph.usart0_mode_select;
         fabric.serial_prog_data_in <= e_in[0]
                                     & periph.prog_mode;
         fabric.jtag_tdi          <= f_in[7] & jen;
         fabric.jtag_tms          <= f_in[5] & jen;
         fabric.jtag_tck          <= f_in[4] & jen;
      end
   end

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   sequence s_req_wait;
      (read | write) && waitrequest;
   endsequence
   sequence s_ack;
      !waitrequest;
   endsequence

   bus_answer_a: assert property (@(posedge clk) disable iff (srst)
      s_req_wait |=> s_ack ##1 waitrequest)
      else $error("bus answer timing wrong");

   tx_drive_a: assert property (@(posedge clk) disable iff (srst)
      !srst && periph.usart0_tx_enable && !periph.prog_mode |=>
      !pe_pad_oe_n[1] && pe_pad_out[1] == $past(periph.usart0_tx_line)
      && !pe_pad_pu[1])
      else $error("transmit pin not driven");

   rx_input_a: assert property (@(posedge clk) disable iff (srst)
      periph.usart0_rx_enable |=> pe_pad_oe_n[0])
      else $error("receive pin not input");

   rx_pullup_a: assert property (@(posedge clk) disable iff (srst)
      periph.usart0_rx_enable |=>
      pe_pad_pu[0] == $past(pe_port_r[0] & ~pud))
      else $error("receive pull-up wrong");

   cmp_drive_a: assert property (@(posedge clk) disable iff (srst)
      !srst && periph.t3_oc_en[2] |=> pe_pad_out[5] == $past(periph.t3_oc[2])
      && pe_pad_oe_n[5] == $past(~pe_ddr_r[5]))
      else $error("compare C pin wrong");

   xck_in_a: assert property (@(posedge clk) disable iff (srst)
      !periph.usart0_mode_select |=> !fabric.usart0_ext_clock)
      else $error("clock used outside sync mode");

   capture_route_a: assert property (@(posedge clk) disable iff (srst)
      periph.irq_en[3] ##1 periph.irq_en[3] |=>
      fabric.timer3_capture_in == $past(pe_pin_q[7])
      && fabric.ext_irq_src[3] == fabric.timer3_capture_in)
      else $error("bit 7 routing wrong");

   jtag_pull_a: assert property (@(posedge clk)
      jen |=> (pf_pad_pu & PEFM_JTAG_PU) == PEFM_JTAG_PU)
      else $error("test pull-ups dropped");

   tdo_drive_a: assert property (@(posedge clk) disable iff (srst)
      !srst && jen && periph.jtag_shift |=>
      !pf_pad_oe_n[6] && pf_pad_out[6] == $past(periph.jtag_tdo))
      else $error("test data out not driven");

   cmp_din_a: assert property (@(posedge clk) disable iff (srst)
      misc_r[PEFM_MISC_POS] |-> !e_in[2])
      else $error("comparator input not disabled");
endmodule
`default_nettype wire

// ==== logic/pefm_pkg.sv ====
// How it works
// - Bit 7 feeds irq seven and capture
// - Bit 6 feeds irq six and count
// - Compare outputs C,B,A set pins 5,4,3 value, direction by bit
// - Pins 7-4 input always enabled; irq enable forces it on
// - Transmitter forces pin 1 output, no pull-up
// - Receiver forces pin 0 to input
// - Receiver input pin pulls up on data one
// - Pin 2 clock direction by bit, value by mode
// - External clock used only in synchronous mode
// - Comparator bits disable pin 3,2 digital inputs
// - Programming uses pin 0 in, pin 1 out
// - Test port keeps F7,5,4 pull-ups, even reset
// - Test port takes F7-4; F7 is data in
// - System clock paces all test port pad updates
// - Test data out drives F6 while shifting
// - F bit n is analog channel n
package pefm_pkg;
   // ----------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------
   localparam logic [7:0] PEFM_PE_OUT  = 8'h00; // Port E data
   localparam logic [7:0] PEFM_PE_DIR  = 8'h04; // Port E direction
   localparam logic [7:0] PEFM_PF_OUT  = 8'h08; // Port F data
   localparam logic [7:0] PEFM_PF_DIR  = 8'h0c; // Port F direction
   localparam logic [7:0] PEFM_MISC    = 8'h10; // Disables, pull-up off
   localparam logic [7:0] PEFM_ADC_DIS = 8'h14; // F digital input off
   localparam logic [7:0] PEFM_PE_PIN  = 8'h18; // Port E pin levels
   localparam logic [7:0] PEFM_PF_PIN  = 8'h1c; // Port F pin levels
   // ----------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------
   localparam int         PEFM_MISC_POS = 0;     // Comparator pos disable
   localparam int         PEFM_MISC_NEG = 1;     // Comparator neg disable
   localparam int         PEFM_MISC_PUD = 2;     // Global pull-up disable
   localparam logic [7:0] PEFM_RST8     = 8'h00; // Byte register reset
   localparam logic [7:0] PEFM_JTAG_PU  = 8'hb0; // F7,F5,F4 pull-ups
   localparam logic [7:0] PEFM_JTAG_PIN = 8'hf0; // F7..F4 taken by test
   // ----------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------
   typedef struct packed {
      logic [3:0] irq_en;              // Ext irq enables, 7..4
      logic [2:0] t3_oc_en;            // Compare enables C,B,A
      logic [2:0] t3_oc;               // Compare levels C,B,A
      logic       usart0_tx_enable;    // Transmitter on
      logic       usart0_rx_enable;    // Receiver on
      logic       usart0_mode_select;  // Synchronous mode
      logic       usart0_tx_line;      // Transmit serial data
      logic       usart0_xck_out;      // Clock to drive out
      logic       prog_mode;           // Serial downloading
      logic       serial_prog_data_out;// Programming data out
      logic       jtag_en;             // Test port enabled
      logic       jtag_shift;          // Shifting IR or DR
      logic       jtag_tdo;            // Test data out
   } pefm_periph_s;
   typedef struct packed {
      logic [3:0] ext_irq_src;         // Irq sources 7..4
      logic       timer3_capture_in;   // Capture trigger
      logic       timer3_count_src;    // Counter clock source
      logic       usart0_rx_line;      // Receive data
      logic       usart0_ext_clock;    // External clock in
      logic       serial_prog_data_in; // Programming data in
      logic       jtag_tdi;            // Test data in
      logic       jtag_tms;            // Test mode select
      logic       jtag_tck;            // Test clock
   } pefm_fabric_s;
   typedef struct packed {
      logic [7:0] pu_oe, pu_ov, dd_oe, dd_ov;
      logic [7:0] pv_oe, pv_ov, die_oe, die_ov;
   } pefm_ovr_s;
endpackage

// ==== tb/pefm_pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pefm_pad_model (
   input  wire logic [7:0] out,    // Device drive value
   input  wire logic [7:0] oe_n,   // Device drive, low on
   input  wire logic [7:0] pu,     // Device pull-ups
   input  wire logic [7:0] ext,    // Tester drive value
   input  wire logic [7:0] ext_en, // Tester drive on
   input  wire logic       clk,    // System clock
   output logic [7:0]      pad     // Resolved pad level
);
   // ----------------------------------------------------------
   // Pad wire resolution
   // ----------------------------------------------------------
   logic [7:0] flt_r = 8'h55; // Undriven pattern, flips each cycle
   // Undriven line without pull-up never holds a stable value
   always_ff @(posedge clk) begin
      flt_r <= ~flt_r;
   end
   // Device first, then tester, then pull-up
   // Tester never overrides a pin the device drives
   // Tester supplies test clock and mode levels here
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!oe_n[i]) begin
            pad[i] = out[i];
         end else if (ext_en[i]) begin
            pad[i] = ext[i];
         end else begin
            pad[i] = pu[i] | flt_r[i];
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/pefm_mux_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pefm_mux_tb;
   import pefm_pkg::*;
   // ----------------------------------------------------------
   // Signals
   // ----------------------------------------------------------
   logic         clk = 1'b0;   // 40 MHz clock
   logic         srst;         // Sync reset
   logic [7:0]   address;      // Bus address
   logic         read, write;  // Bus requests
   logic [3:0]   byteenable;   // Bus lanes
   logic [31:0]  writedata;    // Bus write data
   logic [31:0]  readdata;     // Bus read data
   logic         waitrequest;  // Bus stall
   pefm_periph_s periph;       // Peripheral controls
   pefm_fabric_s fabric;       // Peripheral inputs
   logic [7:0]   pe_in, pe_out, pe_oe_n, pe_pu;          // Port E pads
   logic [7:0]   pf_in, pf_out, pf_oe_n, pf_pu, pf_off;  // Port F pads
   logic [7:0]   pe_ext, pe_ext_en, pf_ext, pf_ext_en;   // Tester drive
   int           n_errors, n_checks; // Counters
   // Half-period toggle
   always #12.5 clk = ~clk;
   pefm_mux u_pefm_mux (.clk(clk), .srst(srst), .address(address),
      .read(read), .write(write), .byteenable(byteenable),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .periph(periph), .fabric(fabric),
      .pe_pad_in(pe_in), .pe_pad_out(pe_out), .pe_pad_oe_n(pe_oe_n),
      .pe_pad_pu(pe_pu), .pf_pad_in(pf_in), .pf_pad_out(pf_out),
      .pf_pad_oe_n(pf_oe_n), .pf_pad_pu(pf_pu), .pf_din_off(pf_off));
   pefm_pad_model u_pad_e (.out(pe_out), .oe_n(pe_oe_n), .pu(pe_pu),
      .ext(pe_ext), .ext_en(pe_ext_en), .clk(clk), .pad(pe_in));
   pefm_pad_model u_pad_f (.out(pf_out), .oe_n(pf_oe_n), .pu(pf_pu),
      .ext(pf_ext), .ext_en(pf_ext_en), .clk(clk), .pad(pf_in));
   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One Avalon transfer, held until waitrequest seen low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      address <= a;
      writedata <= {24'h0, d};
      byteenable <= 4'h1;
      if (wr) begin
         write <= 1'b1;
      end else begin
         read <= 1'b1;
      end
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      if (n >= 20) begin
         n_errors++;
         report_and_stop();
      end
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask
   // Pads settle in 1 edge, fabric inputs in 5
   task automatic settle;
      repeat (6) @(posedge clk);
   endtask
   // Hang guard
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end
   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      srst = 1'b1;
      {address, read, write, byteenable, writedata} = '0;
      periph = '0;
      {pe_ext, pe_ext_en, pf_ext, pf_ext_en} = '0;
      n_errors = 0;
      n_checks = 0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      for (int a = 0; a < 'h18; a += 4) begin
         rd_chk(a[7:0], 32'h0);
      end
      rd_chk(8'h20, 32'h0);
      // Compare outputs, then direction off
      wr(PEFM_PE_DIR, 8'h38);
      rd_chk(PEFM_PE_DIR, 32'h38);
      periph.t3_oc_en <= 3'b111;
      periph.t3_oc <= 3'b101;
      settle();
      chk({pe_out[5:3], pe_oe_n[5:3]}, 6'b101000);
      wr(PEFM_PE_DIR, 8'h00);
      settle();
      chk(pe_oe_n[5:3], 3'b111);
      // Transmitter on pin 1
      wr(PEFM_PE_OUT, 8'h03);
      periph.usart0_tx_enable <= 1'b1;
      periph.usart0_tx_line <= 1'b1;
      settle();
      chk({pe_out[1], pe_oe_n[1], pe_pu[1]}, 3'b100);
      periph.usart0_tx_line <= 1'b0;
      settle();
      chk(pe_out[1], 1'b0);
      // Receiver on pin 0 with direction bit set
      wr(PEFM_PE_DIR, 8'h01);
      periph.usart0_rx_enable <= 1'b1;
      pe_ext_en <= 8'h01;
      pe_ext <= 8'h01;
      settle();
      chk({pe_oe_n[0], pe_pu[0], fabric.usart0_rx_line}, 3'b111);
      pe_ext <= 8'h00;
      wr(PEFM_MISC, 8'h04);
      settle();
      chk({pe_pu[0], fabric.usart0_rx_line}, 2'b00);
      wr(PEFM_MISC, 8'h00);
      periph.usart0_rx_enable <= 1'b0;
      periph.usart0_tx_enable <= 1'b0;
      // Serial programming lines
      periph.prog_mode <= 1'b1;
      periph.serial_prog_data_out <= 1'b1;
      pe_ext <= 8'h01;
      settle();
      chk({pe_out[1], pe_oe_n[1:0], fabric.serial_prog_data_in}, 4'b1011);
      periph.prog_mode <= 1'b0;
      // External clock out, in, disabled input, async mode
      wr(PEFM_PE_DIR, 8'h04);
      periph.usart0_mode_select <= 1'b1;
      periph.usart0_xck_out <= 1'b1;
      settle();
      chk({pe_out[2], pe_oe_n[2]}, 2'b10);
      wr(PEFM_PE_DIR, 8'h00);
      pe_ext_en <= 8'hc4;
      pe_ext <= 8'hc4;
      settle();
      chk({pe_oe_n[2], fabric.usart0_ext_clock}, 2'b11);
      wr(PEFM_MISC, 8'h03);
      settle();
      chk(fabric.usart0_ext_clock, 1'b0);
      wr(PEFM_MISC, 8'h00);
      periph.usart0_mode_select <= 1'b0;
      settle();
      chk(fabric.usart0_ext_clock, 1'b0);
      // Interrupt, capture and count inputs on pins 7, 6
      periph.irq_en <= 4'hc;
      settle();
      chk({fabric.ext_irq_src[3:2], fabric.timer3_capture_in,
           fabric.timer3_count_src, pe_oe_n[7:6]}, 6'h3f);
      // Test port takes F7..F4
      periph.jtag_en <= 1'b1;
      wr(PEFM_PF_DIR, 8'hff);
      wr(PEFM_PF_OUT, 8'hff);
      wr(PEFM_ADC_DIS, 8'hff);
      settle();
      chk({pf_out[7:4], pf_oe_n[7], pf_oe_n[5:4]}, 7'b0000111);
      chk(pf_off, 8'h4f);
      periph.jtag_shift <= 1'b1;
      periph.jtag_tdo <= 1'b1;
      pf_ext_en <= 8'hb0;
      pf_ext <= 8'hb0;
      settle();
      chk({pf_out[6], pf_oe_n[6], fabric.jtag_tdi, fabric.jtag_tms,
           fabric.jtag_tck}, 5'b10111);
      rd_chk(PEFM_PF_PIN, 32'hff);
      // Reset with test port still on
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      chk(pf_pu, PEFM_JTAG_PU);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      chk({pf_pu[7], pf_pu[5:0]}, 7'b1110000);
      // Plain analog channel disables
      periph <= '0;
      wr(PEFM_ADC_DIS, 8'h5a);
      settle();
      chk(pf_off, 8'h5a);
      chk({fabric.jtag_tdi, fabric.jtag_tms, fabric.jtag_tck}, 3'b000);
      report_and_stop();
   end
endmodule
`default_nettype wire
